// ### hdl/adder_link_if.sv
// Purpose: Carrier between the execute unit and its byte adder
// Assumes: Purely combinational signals
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
interface adder_link_if;
  logic [7:0] a;
  logic [7:0] b;
  logic       carry_in;
  logic [7:0] sum;
  logic       carry_out;
  logic       half_out;
  logic       wrap_out;

  modport user (output a, output b, output carry_in,
                input sum, input carry_out, input half_out, input wrap_out);
  modport unit (input a, input b, input carry_in,
                output sum, output carry_out, output half_out, output wrap_out);
endinterface
`default_nettype wire

// ### hdl/bcd_adjust.sv
// Purpose: Decimal adjust of the accumulator after an addition
// Assumes: Half carry and carry come from the last addition
// Notes:   Spill follows the inverted half carry when the low nibble is fixed, as the core does
`timescale 1ns/1ps
`include "exec_unit_cfg.svh"
`default_nettype none
module bcd_adjust (
  input  wire logic [7:0] acc,
  input  wire logic       half_carry_flag,
  input  wire logic       carry_flag,
  output logic      [7:0] result,
  output logic            carry_out
);
  logic       low_fix;
  logic       bcd_low_nibble_spill;
  logic [4:0] high_sum;
  logic       high_fix;

  assign low_fix = (acc[3:0] > `BCD_LIMIT) || half_carry_flag;                 // RULE_12
  assign bcd_low_nibble_spill = low_fix ? !half_carry_flag : 1'b0;             // RULE_12
  assign result[3:0] = low_fix ? acc[3:0] + `BCD_STEP : acc[3:0];              // RULE_12
  assign high_sum = {1'b0, acc[7:4]} + {4'h0, bcd_low_nibble_spill};
  assign high_fix = (high_sum > {1'b0, `BCD_LIMIT}) || carry_flag;             // RULE_13
  assign result[7:4] = high_fix ? high_sum[3:0] + `BCD_STEP : high_sum[3:0];   // RULE_13
  assign carry_out = high_fix ? 1'b1 : carry_flag;                             // RULE_13
endmodule
`default_nettype wire

// ### hdl/byte_adder.sv
// Purpose: 8-bit adder with carry, half carry and signed wrap
// Assumes: Operands held stable by the user
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module byte_adder (
  adder_link_if.unit port
);
  logic [8:0] full;
  logic [4:0] low;

  assign full = {1'b0, port.a} + {1'b0, port.b} + {8'h00, port.carry_in};
  assign low  = {1'b0, port.a[3:0]} + {1'b0, port.b[3:0]} + {4'h0, port.carry_in};
  assign port.sum       = full[7:0];                                       // RULE_20
  assign port.carry_out = full[8];                                         // RULE_19
  assign port.half_out  = low[4];                                          // RULE_19
  assign port.wrap_out  = (port.a[7] == port.b[7]) && (full[7] != port.a[7]); // RULE_19
endmodule
`default_nettype wire

// ### hdl/exec_unit_cfg.svh
// Purpose: Constants for the 8-bit instruction execute unit
// Assumes: Included by bare name from the design files
// Notes:   Timing figures are in system clocks
//
// Overview of operation
// [RULE_01] Add-with-carry to accumulator: acc+mem+carry into acc, four arithmetic flags.
// [RULE_02] Add-with-carry into memory: acc+mem+carry into memory, four arithmetic flags.
// [RULE_03] Plain add: acc plus memory or immediate into acc, four arithmetic flags.
// [RULE_04] Sum into memory: acc plus memory stored to memory, four arithmetic flags.
// [RULE_05] Mask ops AND acc with memory or immediate; only zero flag changes.
// [RULE_06] Call pushes pc+1, loads target, flags untouched.
// [RULE_07] Zero-memory writes 00 to memory, flags untouched.
// [RULE_08] Bit clear zeroes one selected memory bit, rest and flags untouched.
// [RULE_09] Watchdog kick clears counter, expired flag and sleep flag.
// [RULE_10] Both half kicks needed to clear watchdog; one alone only records itself.
// [RULE_11] Invert gives ones complement to memory or acc; only zero flag.
// [RULE_12] BCD low nibble: add 6 if above 9 or half carry; spill is inverted half carry.
// [RULE_13] BCD high nibble plus spill: add 6, set carry if above 9 or carry.
// [RULE_14] Minus-one to memory or acc; only zero flag updated.
// [RULE_15] Plus-one to memory or acc; only zero flag updated.
// [RULE_16] Halt advances pc, stops, clears watchdog and prescaler, sets sleep, clears expired.
// [RULE_17] Direct branch loads pc with the instruction target.
// [RULE_18] Writing program counter low or a taken skip adds one four-clock cycle.
// [RULE_19] Zero on zero result; carry bit 7, half carry bit 3, signed overflow.
// [RULE_20] Results are cut to 8 bits before being written.
`ifndef EXEC_UNIT_CFG_SVH
`define EXEC_UNIT_CFG_SVH

`define CLOCKS_PER_CYCLE   4'd4
`define PC_WIDTH_DEF       11
`define STACK_DEPTH_DEF    8
`define PRESCALE_BITS_DEF  8
`define WATCHDOG_BITS_DEF  8
`define PROGRAM_COUNTER_LOW_ADDR 8'h06
`define ACC_RESET          8'h00
`define FLAG_RESET         1'b0
`define BCD_LIMIT          4'h9
`define BCD_STEP           4'h6

`endif

// ### hdl/exec_unit_pkg.sv
// Purpose: Types shared by the execute unit files
// Assumes: Used as exec_unit_pkg::name, never imported
// Notes:   Opcode codes are internal, not the program memory encoding
package exec_unit_pkg;

  typedef enum logic [4:0] {
    OP_NONE          = 5'b00000,
    OP_ADD_CARRY_ACC = 5'b00001,
    OP_ADD_CARRY_MEM = 5'b00010,
    OP_ADD_ACC       = 5'b00011,
    OP_ADD_IMM       = 5'b00100,
    OP_SUM_MEM       = 5'b00101,
    OP_MASK_ACC      = 5'b00110,
    OP_MASK_IMM      = 5'b00111,
    OP_MASK_MEM      = 5'b01000,
    OP_CALL          = 5'b01001,
    OP_ZERO_MEM      = 5'b01010,
    OP_BIT_ZERO      = 5'b01011,
    OP_KICK          = 5'b01100,
    OP_HALF_ONE      = 5'b01101,
    OP_HALF_TWO      = 5'b01110,
    OP_INVERT_MEM    = 5'b01111,
    OP_INVERT_ACC    = 5'b10000,
    OP_BCD_ADJUST    = 5'b10001,
    OP_MINUS_MEM     = 5'b10010,
    OP_MINUS_ACC     = 5'b10011,
    OP_PLUS_MEM      = 5'b10100,
    OP_PLUS_ACC      = 5'b10101,
    OP_HALT          = 5'b10110,
    OP_BRANCH        = 5'b10111
  } op_e;

endpackage

// ### hdl/mcu_instruction_execute_unit.sv
// Purpose: Executes one decoded instruction per request, four clocks a cycle
// Assumes: Operand byte is read before the request; memory write is a pulse
// Notes:   Watchdog expiry flags and wakes, it does not reset the core
`timescale 1ns/1ps
`include "exec_unit_cfg.svh"
`default_nettype none
module mcu_instruction_execute_unit #(
  parameter int PC_WIDTH      = `PC_WIDTH_DEF,
  parameter int STACK_DEPTH   = `STACK_DEPTH_DEF,
  parameter int PRESCALE_BITS = `PRESCALE_BITS_DEF,
  parameter int WATCHDOG_BITS = `WATCHDOG_BITS_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire exec_unit_pkg::op_e   op,
  input  wire logic [7:0]           mem_addr,
  input  wire logic [7:0]           mem_rd_data,
  input  wire logic [7:0]           imm,
  input  wire logic [2:0]           bit_sel,
  input  wire logic [PC_WIDTH-1:0]  target,
  input  wire logic                 skip_taken,
  input  wire logic                 wake,
  output logic                      ready,
  output logic                      done,
  output logic                      halted,
  output logic                      mem_we,
  output logic [7:0]                mem_wr_addr,
  output logic [7:0]                mem_wr_data,
  output logic [7:0]                acc,
  output logic [PC_WIDTH-1:0]       pc,
  output logic                      carry_flag,
  output logic                      half_carry_flag,
  output logic                      zero_flag,
  output logic                      signed_wrap_flag,
  output logic                      watchdog_expired_flag,
  output logic                      sleep_entered_flag,
  output logic [WATCHDOG_BITS-1:0]  watchdog_counter
);
  localparam int SP_BITS = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  adder_link_if add_bus ();

  byte_adder u_adder (
    .port (add_bus.unit)
  );

  logic [7:0] bcd_result;
  logic       bcd_carry;

  bcd_adjust u_bcd (
    .acc             (acc),
    .half_carry_flag (half_carry_flag),
    .carry_flag      (carry_flag),
    .result          (bcd_result),
    .carry_out       (bcd_carry)
  );

  // Sequencing state
  logic                     running;
  logic [3:0]               remain;
  logic [PC_WIDTH-1:0]      stack_mem [STACK_DEPTH];
  logic [SP_BITS-1:0]       sp;
  logic [PRESCALE_BITS-1:0] prescale;
  logic                     half_one_seen;
  logic                     half_two_seen;

  // Opcode decode
  logic take;
  logic is_carry_add;
  logic is_add;
  logic is_mask;
  logic is_invert;
  logic is_minus;
  logic is_plus;
  logic is_step;
  logic is_bit_zero;
  logic is_zero_mem;
  logic is_bcd;
  logic is_call;
  logic is_branch;
  logic is_halt;
  logic is_kick;
  logic is_half_one;
  logic is_half_two;
  logic dest_acc;
  logic dest_mem;

  assign take         = start && ready;
  assign is_carry_add = (op == exec_unit_pkg::OP_ADD_CARRY_ACC)
                     || (op == exec_unit_pkg::OP_ADD_CARRY_MEM);
  assign is_add       = is_carry_add
                     || (op == exec_unit_pkg::OP_ADD_ACC)
                     || (op == exec_unit_pkg::OP_ADD_IMM)
                     || (op == exec_unit_pkg::OP_SUM_MEM);
  assign is_mask      = (op == exec_unit_pkg::OP_MASK_ACC)
                     || (op == exec_unit_pkg::OP_MASK_IMM)
                     || (op == exec_unit_pkg::OP_MASK_MEM);
  assign is_invert    = (op == exec_unit_pkg::OP_INVERT_MEM)
                     || (op == exec_unit_pkg::OP_INVERT_ACC);
  assign is_minus     = (op == exec_unit_pkg::OP_MINUS_MEM)
                     || (op == exec_unit_pkg::OP_MINUS_ACC);
  assign is_plus      = (op == exec_unit_pkg::OP_PLUS_MEM)
                     || (op == exec_unit_pkg::OP_PLUS_ACC);
  assign is_step      = is_minus || is_plus;
  assign is_bit_zero  = (op == exec_unit_pkg::OP_BIT_ZERO);
  assign is_zero_mem  = (op == exec_unit_pkg::OP_ZERO_MEM);
  assign is_bcd       = (op == exec_unit_pkg::OP_BCD_ADJUST);
  assign is_call      = (op == exec_unit_pkg::OP_CALL);
  assign is_branch    = (op == exec_unit_pkg::OP_BRANCH);
  assign is_halt      = (op == exec_unit_pkg::OP_HALT);
  assign is_kick      = (op == exec_unit_pkg::OP_KICK);
  assign is_half_one  = (op == exec_unit_pkg::OP_HALF_ONE);
  assign is_half_two  = (op == exec_unit_pkg::OP_HALF_TWO);

  assign dest_acc = (op == exec_unit_pkg::OP_ADD_CARRY_ACC)
                 || (op == exec_unit_pkg::OP_ADD_ACC)
                 || (op == exec_unit_pkg::OP_ADD_IMM)
                 || (op == exec_unit_pkg::OP_MASK_ACC)
                 || (op == exec_unit_pkg::OP_MASK_IMM)
                 || (op == exec_unit_pkg::OP_INVERT_ACC)   // RULE_11
                 || (op == exec_unit_pkg::OP_MINUS_ACC)    // RULE_14
                 || (op == exec_unit_pkg::OP_PLUS_ACC);    // RULE_15
  assign dest_mem = (op == exec_unit_pkg::OP_ADD_CARRY_MEM) // RULE_02
                 || (op == exec_unit_pkg::OP_SUM_MEM)       // RULE_04
                 || (op == exec_unit_pkg::OP_MASK_MEM)
                 || (op == exec_unit_pkg::OP_INVERT_MEM)
                 || (op == exec_unit_pkg::OP_MINUS_MEM)
                 || (op == exec_unit_pkg::OP_PLUS_MEM)
                 || is_zero_mem || is_bit_zero
                 || is_bcd;                                 // RULE_13

  // Operand routing into the shared adder
  logic [7:0] operand_b;
  logic [7:0] step_value;

  assign operand_b  = ((op == exec_unit_pkg::OP_ADD_IMM)
                    || (op == exec_unit_pkg::OP_MASK_IMM)) ? imm : mem_rd_data; // RULE_03
  assign step_value = is_minus ? 8'hff : 8'h01;                        // RULE_14 RULE_15
  assign add_bus.a  = is_step ? mem_rd_data : acc;
  assign add_bus.b  = is_step ? step_value : operand_b;
  assign add_bus.carry_in = is_carry_add ? carry_flag : 1'b0;          // RULE_01 RULE_02

  // Result selection, always 8 bits wide
  logic [7:0] bit_mask;
  logic [7:0] result;
  logic       result_zero;

  assign bit_mask = 8'(8'h01 << bit_sel);
  assign result =
      (is_add || is_step) ? add_bus.sum :                              // RULE_20
      is_mask             ? (acc & operand_b) :                        // RULE_05
      is_invert           ? ~mem_rd_data :                             // RULE_11
      is_bit_zero         ? (mem_rd_data & ~bit_mask) :                // RULE_08
      is_bcd              ? bcd_result :                               // RULE_12 RULE_13
                            8'h00;                                     // RULE_07
  assign result_zero = (result == 8'h00);                              // RULE_19

  // Cycle length: base cycles plus one for a low counter write or skip
  logic       pcl_write;
  logic [3:0] base_cycles;
  logic [3:0] total_cycles;
  logic [3:0] total_clocks;

  assign pcl_write    = dest_mem && (mem_addr == `PROGRAM_COUNTER_LOW_ADDR);
  assign base_cycles  = (is_call || is_branch) ? 4'd2 : 4'd1;
  assign total_cycles = base_cycles + ((pcl_write || skip_taken) ? 4'd1 : 4'd0); // RULE_18
  assign total_clocks = 4'(total_cycles * `CLOCKS_PER_CYCLE);                    // RULE_18

  assign ready = !running && !halted;
  assign done  = running && (remain == 4'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      remain  <= 4'd0;
    end else if (take) begin
      running <= 1'b1;
      remain  <= total_clocks - 4'd1;                                  // RULE_18
    end else if (running) begin
      running <= (remain != 4'd1);
      remain  <= remain - 4'd1;
    end
  end

  // Program counter and return stack
  logic [PC_WIDTH-1:0] pc_next_seq;

  assign pc_next_seq = pc + PC_WIDTH'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= '0;
      sp <= '0;
    end else if (take) begin
      if (is_call || is_branch) begin
        pc <= target;                                                  // RULE_06 RULE_17
      end else if (pcl_write) begin
        pc <= {pc_next_seq[PC_WIDTH-1:8], result};
      end else begin
        pc <= pc_next_seq;                                             // RULE_16
      end
      if (is_call) begin
        sp <= SP_BITS'(sp + SP_BITS'(1));                              // RULE_06
      end
    end
  end

  // Stack storage has no reset; only the pointer matters after reset
  always_ff @(posedge clk) begin
    if (take && is_call) begin
      stack_mem[sp] <= pc_next_seq;                                    // RULE_06
    end
  end

  // Accumulator and arithmetic flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc              <= `ACC_RESET;
      carry_flag       <= `FLAG_RESET;
      half_carry_flag  <= `FLAG_RESET;
      zero_flag        <= `FLAG_RESET;
      signed_wrap_flag <= `FLAG_RESET;
    end else if (take) begin
      if (dest_acc) begin
        acc <= result;                                           // RULE_01 RULE_03 RULE_05
      end
      if (is_add) begin
        carry_flag       <= add_bus.carry_out;                   // RULE_01 RULE_02 RULE_03 RULE_04
        half_carry_flag  <= add_bus.half_out;                    // RULE_19
        signed_wrap_flag <= add_bus.wrap_out;                    // RULE_19
      end else if (is_bcd) begin
        carry_flag <= bcd_carry;                                 // RULE_13
      end
      if (is_add || is_mask || is_invert || is_step) begin
        zero_flag <= result_zero;                                // RULE_05 RULE_11 RULE_14 RULE_15
      end
    end
  end

  // Memory write port, one pulse after the request is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we      <= 1'b0;
      mem_wr_addr <= 8'h00;
      mem_wr_data <= 8'h00;
    end else begin
      mem_we <= take && dest_mem;                                // RULE_02 RULE_07 RULE_08
      if (take && dest_mem) begin
        mem_wr_addr <= mem_addr;
        mem_wr_data <= result;                                   // RULE_04 RULE_11 RULE_14
      end
    end
  end

  // Watchdog: prescaler feeds the counter; expiry flags and wakes
  logic half_complete;
  logic counter_clear;
  logic prescale_clear;
  logic prescale_wrap;
  logic expiry;
  logic flags_clear;

  assign half_complete  = take && ((is_half_one && half_two_seen)
                               || (is_half_two && half_one_seen));      // RULE_10
  assign flags_clear    = (take && is_kick) || half_complete;           // RULE_09 RULE_10
  assign counter_clear  = flags_clear || (take && is_halt);             // RULE_16
  assign prescale_clear = take && is_halt;                              // RULE_16
  assign prescale_wrap  = &prescale;
  assign expiry         = prescale_wrap && (&watchdog_counter);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale         <= '0;
      watchdog_counter <= '0;
    end else begin
      prescale <= prescale_clear ? '0 : prescale + PRESCALE_BITS'(1);
      if (counter_clear) begin
        watchdog_counter <= '0;                                         // RULE_09
      end else if (prescale_wrap) begin
        watchdog_counter <= watchdog_counter + WATCHDOG_BITS'(1);
      end
    end
  end

  // A lone half kick only records itself; a second of the same kind is idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_one_seen <= 1'b0;
      half_two_seen <= 1'b0;
    end else if (flags_clear) begin
      half_one_seen <= 1'b0;                                            // RULE_10
      half_two_seen <= 1'b0;
    end else if (take && is_half_one) begin
      half_one_seen <= 1'b1;                                            // RULE_10
    end else if (take && is_half_two) begin
      half_two_seen <= 1'b1;                                            // RULE_10
    end
  end

  // Expiry beats a clear arriving in the same clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_expired_flag <= `FLAG_RESET;
      sleep_entered_flag    <= `FLAG_RESET;
    end else begin
      if (expiry) begin
        watchdog_expired_flag <= 1'b1;
      end else if (flags_clear || (take && is_halt)) begin
        watchdog_expired_flag <= 1'b0;                                  // RULE_09 RULE_16
      end
      if (take && is_halt) begin
        sleep_entered_flag <= 1'b1;                                     // RULE_16
      end else if (flags_clear) begin
        sleep_entered_flag <= 1'b0;                                     // RULE_09 RULE_10
      end
    end
  end

  // Halt blocks new requests while the watchdog keeps counting; wake input or expiry resumes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (take && is_halt) begin
      halted <= 1'b1;                                                   // RULE_16
    end else if (wake || expiry) begin
      halted <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### verification/exec_unit_props.sv
// Purpose: Port-level checks of the execute unit
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound onto every instance of the execute unit
`timescale 1ns/1ps
`default_nettype none
module exec_unit_props #(
  parameter int PC_WIDTH = 11
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                start,
  input wire exec_unit_pkg::op_e  op,
  input wire logic [7:0]          mem_rd_data,
  input wire logic [7:0]          imm,
  input wire logic [PC_WIDTH-1:0] target,
  input wire logic                skip_taken,
  input wire logic                ready,
  input wire logic                halted,
  input wire logic                mem_we,
  input wire logic [7:0]          mem_wr_data,
  input wire logic [7:0]          acc,
  input wire logic [PC_WIDTH-1:0] pc,
  input wire logic                carry_flag,
  input wire logic                zero_flag,
  input wire logic                watchdog_expired_flag,
  input wire logic                sleep_entered_flag
);
  wire take = start && ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_short: assert property (take && op == exec_unit_pkg::OP_MASK_IMM && !skip_taken
    |=> !ready [*3] ##1 ready) else $error("one-cycle op did not last four clocks");
  a_ready_skip: assert property (take && op == exec_unit_pkg::OP_MASK_IMM && skip_taken
    |=> !ready [*7] ##1 ready) else $error("skipped op did not last eight clocks");
  a_mask_imm: assert property (take && op == exec_unit_pkg::OP_MASK_IMM
    |=> acc == ($past(acc) & $past(imm)) && zero_flag == (acc == 8'h00)
        && carry_flag == $past(carry_flag)) else $error("mask with immediate wrong");
  a_plus_acc: assert property (take && op == exec_unit_pkg::OP_PLUS_ACC
    |=> acc == $past(mem_rd_data) + 8'h01 && zero_flag == (acc == 8'h00))
    else $error("plus one to accumulator wrong");
  a_call_keep: assert property (take && op == exec_unit_pkg::OP_CALL
    |=> pc == $past(target) && $stable({carry_flag, zero_flag}))
    else $error("call target or flags wrong");
  a_branch_pc: assert property (take && op == exec_unit_pkg::OP_BRANCH
    |=> pc == $past(target)) else $error("branch target not loaded");
  a_zero_write: assert property (take && op == exec_unit_pkg::OP_ZERO_MEM
    |=> mem_we && mem_wr_data == 8'h00) else $error("zero write missing");
  a_kick_clear: assert property (take && op == exec_unit_pkg::OP_KICK
    |=> !watchdog_expired_flag && !sleep_entered_flag) else $error("kick left a flag set");
  a_halt_state: assert property (take && op == exec_unit_pkg::OP_HALT
    |=> halted && sleep_entered_flag && !watchdog_expired_flag && !ready)
    else $error("halt state wrong");
endmodule

bind mcu_instruction_execute_unit exec_unit_props #(.PC_WIDTH(PC_WIDTH)) props_u (
  .clk, .rst_n, .start, .op, .mem_rd_data, .imm, .target, .skip_taken, .ready, .halted,
  .mem_we, .mem_wr_data, .acc, .pc, .carry_flag, .zero_flag, .watchdog_expired_flag,
  .sleep_entered_flag);
`default_nettype wire

// ### verification/mcu_instruction_execute_unit_test.sv
// Purpose: Directed test of the execute unit operations
// Assumes: Default parameters; inputs change on the falling edge
// Notes:   Expected flags are packed as carry, half carry, zero, signed wrap
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute_unit_test;
  logic               clk, rst_n, start, skip_taken, wake;
  exec_unit_pkg::op_e op;
  logic [7:0]         mem_addr, mem_rd_data, imm, mem_wr_addr, mem_wr_data, acc, watchdog_counter;
  logic [2:0]         bit_sel;
  logic [10:0]        target, pc;
  logic               ready, done, halted, mem_we, carry_flag, half_carry_flag, zero_flag;
  logic               signed_wrap_flag, watchdog_expired_flag, sleep_entered_flag;
  int                 failures, n_compared, n_writes, cycles, n_done;

  mcu_instruction_execute_unit dut_u (.clk, .rst_n, .start, .op, .mem_addr, .mem_rd_data, .imm,
    .bit_sel, .target, .skip_taken, .wake, .ready, .done, .halted, .mem_we, .mem_wr_addr,
    .mem_wr_data, .acc, .pc, .carry_flag, .half_carry_flag, .zero_flag, .signed_wrap_flag,
    .watchdog_expired_flag, .sleep_entered_flag, .watchdog_counter);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem_we === 1'b1) n_writes <= n_writes + 1;
    if (done === 1'b1) n_done <= n_done + 1;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Called at a falling edge with ready high; w[8] asks for a write check
  task automatic run(input exec_unit_pkg::op_e o, input logic [7:0] rd, input logic [7:0] im,
                     input logic [7:0] a, input logic [3:0] f, input logic [8:0] w);
    op = o;
    mem_rd_data = rd;
    imm = im;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    cycles = 1;
    while (!ready && cycles < 40) begin
      if (cycles == 8 && o == exec_unit_pkg::OP_HALT) begin
        chk("halted", 16'h0001, {15'h0000, halted});
        wake = 1'b1;
      end
      @(negedge clk);
      cycles++;
    end
    wake = 1'b0;
    chk("ready", 16'h0001, {15'h0000, ready});
    chk("acc", {8'h00, a}, {8'h00, acc});
    chk("flags", 16'(f), {12'h000, carry_flag, half_carry_flag, zero_flag, signed_wrap_flag});
    if (w[8]) chk("mem_wr", {mem_addr, w[7:0]}, {mem_wr_addr, mem_wr_data});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole sequence is a few hundred clocks
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    op = exec_unit_pkg::OP_NONE;
    mem_addr = 8'h20;
    mem_rd_data = 8'h00;
    imm = 8'h00;
    bit_sel = 3'h5;
    target = 11'h155;
    skip_taken = 1'b0;
    wake = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("pc", 16'h0000, {5'h00, pc});
    run(exec_unit_pkg::OP_ADD_IMM, 8'h00, 8'h3a, 8'h3a, 4'h0, 9'h000);
    run(exec_unit_pkg::OP_ADD_ACC, 8'h46, 8'h00, 8'h80, 4'h5, 9'h000);
    run(exec_unit_pkg::OP_ADD_CARRY_ACC, 8'h80, 8'h00, 8'h00, 4'hb, 9'h000);
    run(exec_unit_pkg::OP_ADD_CARRY_MEM, 8'h0f, 8'h00, 8'h00, 4'h4, 9'h110);
    run(exec_unit_pkg::OP_ADD_IMM, 8'h00, 8'hf5, 8'hf5, 4'h0, 9'h000);
    run(exec_unit_pkg::OP_MASK_MEM, 8'h0a, 8'h00, 8'hf5, 4'h2, 9'h100);
    run(exec_unit_pkg::OP_MASK_ACC, 8'h0f, 8'h00, 8'h05, 4'h0, 9'h000);
    run(exec_unit_pkg::OP_SUM_MEM, 8'hfb, 8'h00, 8'h05, 4'he, 9'h100);
    run(exec_unit_pkg::OP_MASK_IMM, 8'h00, 8'h07, 8'h05, 4'hc, 9'h000);
    run(exec_unit_pkg::OP_INVERT_ACC, 8'h0f, 8'h00, 8'hf0, 4'hc, 9'h000);
    run(exec_unit_pkg::OP_INVERT_MEM, 8'hff, 8'h00, 8'hf0, 4'he, 9'h100);
    run(exec_unit_pkg::OP_PLUS_ACC, 8'hff, 8'h00, 8'h00, 4'he, 9'h000);
    run(exec_unit_pkg::OP_MINUS_MEM, 8'h00, 8'h00, 8'h00, 4'hc, 9'h1ff);
    run(exec_unit_pkg::OP_MINUS_ACC, 8'h01, 8'h00, 8'h00, 4'he, 9'h000);
    run(exec_unit_pkg::OP_PLUS_MEM, 8'h41, 8'h00, 8'h00, 4'hc, 9'h142);
    run(exec_unit_pkg::OP_ZERO_MEM, 8'h5a, 8'h00, 8'h00, 4'hc, 9'h100);
    run(exec_unit_pkg::OP_BIT_ZERO, 8'hff, 8'h00, 8'h00, 4'hc, 9'h1df);
    run(exec_unit_pkg::OP_BCD_ADJUST, 8'h00, 8'h00, 8'h00, 4'hc, 9'h166);
    run(exec_unit_pkg::OP_ADD_IMM, 8'h00, 8'h9b, 8'h9b, 4'h0, 9'h000);
    run(exec_unit_pkg::OP_BCD_ADJUST, 8'h00, 8'h00, 8'h9b, 4'h8, 9'h101);
    run(exec_unit_pkg::OP_ADD_IMM, 8'h00, 8'h9d, 8'h38, 4'hd, 9'h000);
    run(exec_unit_pkg::OP_BCD_ADJUST, 8'h00, 8'h00, 8'h38, 4'hd, 9'h19e);
    run(exec_unit_pkg::OP_ADD_IMM, 8'h00, 8'h01, 8'h39, 4'h0, 9'h000);
    run(exec_unit_pkg::OP_BCD_ADJUST, 8'h00, 8'h00, 8'h39, 4'h0, 9'h139);
    run(exec_unit_pkg::OP_CALL, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    chk("pc", 16'h0155, {5'h00, pc});
    chk("cycles", 16'h0008, cycles[15:0]);
    target = 11'h2aa;
    run(exec_unit_pkg::OP_BRANCH, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    chk("pc", 16'h02aa, {5'h00, pc});
    skip_taken = 1'b1;
    run(exec_unit_pkg::OP_MASK_IMM, 8'h00, 8'hff, 8'h39, 4'h0, 9'h000);
    skip_taken = 1'b0;
    chk("cycles", 16'h0008, cycles[15:0]);
    mem_addr = 8'h06;
    run(exec_unit_pkg::OP_ZERO_MEM, 8'h77, 8'h00, 8'h39, 4'h0, 9'h100);
    mem_addr = 8'h20;
    chk("cycles", 16'h0008, cycles[15:0]);
    chk("pc_low", 16'h0000, {8'h00, pc[7:0]});
    run(exec_unit_pkg::OP_HALT, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    chk("sleep_exp", 16'h0002, {14'h0000, sleep_entered_flag, watchdog_expired_flag});
    run(exec_unit_pkg::OP_HALF_ONE, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    run(exec_unit_pkg::OP_HALF_ONE, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    chk("sleep_exp", 16'h0002, {14'h0000, sleep_entered_flag, watchdog_expired_flag});
    run(exec_unit_pkg::OP_HALF_TWO, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    chk("sleep_exp", 16'h0000, {14'h0000, sleep_entered_flag, watchdog_expired_flag});
    run(exec_unit_pkg::OP_HALT, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    repeat (256) @(negedge clk);
    run(exec_unit_pkg::OP_KICK, 8'h00, 8'h00, 8'h39, 4'h0, 9'h000);
    chk("kick", 16'h0000, {6'h00, watchdog_counter,
        sleep_entered_flag, watchdog_expired_flag});
    chk("writes", 16'h000d, n_writes[15:0]);
    chk("done", 16'h0022, n_done[15:0]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
